// >>> pkg/deadman_pkg.sv
/*
  Shared constants for the instruction-fetch deadman supervisor:
  register offsets, field positions, key patterns, reset values and
  the bus answer codes. Assumes AXI4-Lite with 32-bit data and a
  12-bit byte address window for the register file.
*/
package deadman_pkg;
  // Bus and register widths
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;
  localparam int unsigned REG_W = 16;
  localparam int unsigned KEY_W = 8;
  localparam int unsigned CNT_W = 32;

  // Register byte offsets, one aligned word each
  localparam logic [11:0] OFF_CONTROL = 12'h000;
  localparam logic [11:0] OFF_PRECLEAR = 12'h004;
  localparam logic [11:0] OFF_CLEAR = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  localparam logic [11:0] OFF_COUNT_LOW = 12'h010;
  localparam logic [11:0] OFF_COUNT_HIGH = 12'h014;
  localparam logic [11:0] OFF_CFG_COUNT_LOW = 12'h018;
  localparam logic [11:0] OFF_CFG_COUNT_HIGH = 12'h01c;
  localparam logic [11:0] OFF_CFG_INTV_LOW = 12'h020;
  localparam logic [11:0] OFF_CFG_INTV_HIGH = 12'h024;
  localparam logic [11:0] OFF_HOLD = 12'h028;

  // Field positions
  localparam int unsigned CTRL_ON_BIT = 15;
  localparam int unsigned PRECLEAR_KEY_LSB = 8;
  localparam int unsigned CLEAR_KEY_LSB = 0;
  localparam int unsigned STAT_PRE_ERR_BIT = 7;
  localparam int unsigned STAT_CLR_ERR_BIT = 6;
  localparam int unsigned STAT_EVENT_BIT = 5;
  localparam int unsigned STAT_WIN_BIT = 0;
  localparam int unsigned LANE_LO = 0;
  localparam int unsigned LANE_HI = 1;

  // Key patterns
  localparam logic [7:0] PRECLEAR_KEY_VALUE = 8'h40;
  localparam logic [7:0] CLEAR_KEY_VALUE = 8'h08;

  // Reset values and the count step
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_STEP = 32'h0000_0001;

  // Bus answer codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Read channel states of the bus slave
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_ACCEPT = 2'b01,
    RD_RESP = 2'b10
  } rd_state_t;
endpackage

// >>> verilog/fetch_counter.sv
/*
  Holds the 32-bit fetch count and compares it with the match value.
  Assumes the caller gates the advance and never advances past match.
*/
module fetch_counter (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic advance_i,
  input wire logic restart_i,
  input wire logic [31:0] match_i,
  output logic [31:0] count_o,
  output logic expired_o
);
  // Count register; a restart beats an advance in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= deadman_pkg::COUNT_RESET;
    end else if (restart_i) begin
      count_o <= deadman_pkg::COUNT_RESET;
    end else if (advance_i) begin
      count_o <= count_o + deadman_pkg::COUNT_STEP;
    end
  end

  // Match seen straight from the count
  assign expired_o = (count_o == match_i);
endmodule

// >>> verilog/axil_reg_slave.sv
/*
  AXI4-Lite slave front end. Turns bus transfers into one-cycle
  register read and write strobes. Assumes one write and one read at
  most under way, and that rd_data_i and the error flags are decoded
  combinationally from the presented address.
*/
module axil_reg_slave (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic wr_en_o,
  output logic [11:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic [3:0] wr_strb_o,
  input wire logic wr_err_i,
  output logic rd_en_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_err_i
);
  deadman_pkg::rd_state_t rd_state_r; // Read channel state
  logic aw_got_r; // Write address held
  logic w_got_r; // Write data held

  // Write fires once both halves are in and no answer is pending
  assign wr_en_o = aw_got_r && w_got_r && !s_axi_bvalid_o;
  // Read decode happens while arready is up, address still stable
  assign rd_en_o = (rd_state_r == deadman_pkg::RD_ACCEPT);

  // Write address channel; taken independently of data
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_awready_o <= 1'b0;
      aw_got_r <= 1'b0;
      wr_addr_o <= 12'h000;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      s_axi_awready_o <= 1'b0;
      aw_got_r <= 1'b1;
      wr_addr_o <= s_axi_awaddr_i;
    end else if (wr_en_o) begin
      aw_got_r <= 1'b0;
    end else if (s_axi_awvalid_i && !aw_got_r) begin
      s_axi_awready_o <= 1'b1;
    end
  end

  // Write data channel; mirrors the address side
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_wready_o <= 1'b0;
      w_got_r <= 1'b0;
      wr_data_o <= 32'h0000_0000;
      wr_strb_o <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      s_axi_wready_o <= 1'b0;
      w_got_r <= 1'b1;
      wr_data_o <= s_axi_wdata_i;
      wr_strb_o <= s_axi_wstrb_i;
    end else if (wr_en_o) begin
      w_got_r <= 1'b0;
    end else if (s_axi_wvalid_i && !w_got_r) begin
      s_axi_wready_o <= 1'b1;
    end
  end

  // Write response follows the strobe by one edge
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= deadman_pkg::RESP_OKAY;
    end else if (wr_en_o) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_err_i ? deadman_pkg::RESP_SLVERR
                                : deadman_pkg::RESP_OKAY;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Read channel: idle, accept with data capture, then answer
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_state_r <= deadman_pkg::RD_IDLE;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= deadman_pkg::RESP_OKAY;
    end else begin
      unique case (rd_state_r)
        deadman_pkg::RD_IDLE: begin
          if (s_axi_arvalid_i) begin
            s_axi_arready_o <= 1'b1;
            rd_state_r <= deadman_pkg::RD_ACCEPT;
          end
        end
        deadman_pkg::RD_ACCEPT: begin
          s_axi_arready_o <= 1'b0;
          s_axi_rvalid_o <= 1'b1;
          s_axi_rdata_o <= rd_data_i;
          s_axi_rresp_o <= rd_err_i ? deadman_pkg::RESP_SLVERR
                                    : deadman_pkg::RESP_OKAY;
          rd_state_r <= deadman_pkg::RD_RESP;
        end
        deadman_pkg::RD_RESP: begin
          if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            rd_state_r <= deadman_pkg::RD_IDLE;
          end
        end
        default: begin
          rd_state_r <= deadman_pkg::RD_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> verilog/deadman_supervisor.sv
/*
  Instruction-fetch deadman supervisor with its register file.
  Counts fetches, raises an interrupt on match or on a bad key, and is
  kept alive by a two-step key sequence. Assumes fetch_i pulses once
  per fetch synchronous to ref_clk_i and fuse words are static.
*/
module deadman_supervisor (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // AXI4-Lite register port
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Processor side
  input wire logic fetch_i,
  input wire logic sleep_i,
  // Fuse configuration
  input wire logic fuse_enable_i,
  input wire logic fuse_disable_setting_i,
  input wire logic [15:0] fuse_match_low_i,
  input wire logic [15:0] fuse_match_high_i,
  input wire logic [15:0] fuse_interval_low_i,
  input wire logic [15:0] fuse_interval_high_i,
  // Interrupt to the processor
  output logic irq_o
);
  // Widen a 16-bit register to a bus word, upper bits zero
  function automatic logic [31:0] widen(input logic [15:0] v);
    widen = {{(deadman_pkg::DATA_W - deadman_pkg::REG_W){1'b0}}, v};
  endfunction

  // Register strobes from the bus front end
  logic wr_en; // One-cycle write strobe
  logic [11:0] wr_addr; // Write byte address
  logic [31:0] wr_data; // Write data word
  logic [3:0] wr_strb; // Write byte enables
  logic wr_err; // Write to unmapped address
  logic rd_en; // One-cycle read strobe
  logic [31:0] rd_data; // Decoded read word
  logic rd_err; // Read of unmapped address

  // Block state
  logic on_r; // Software enable bit
  logic [7:0] preclear_key_field_r; // Step-one key store
  logic [7:0] clear_key_field_r; // Step-two key store
  logic preclear_key_error_r; // Bad step-one key seen
  logic clear_key_error_r; // Bad step-two key seen
  logic supervisor_event_flag_r; // Expiry or bad key seen
  logic [15:0] upper_count_hold_r; // Upper count at last read
  logic irq_r; // Registered interrupt

  // Derived signals
  logic [31:0] configured_match_value; // Fuse match word
  logic [31:0] configured_interval_value; // Fuse window word
  logic [31:0] count; // Live fetch count
  logic expired; // Count reached match
  logic active; // Timer enabled
  logic advance; // Count one fetch
  logic clear_window_open; // Count reached interval; status bit only, clears are not gated
  logic pre_wr; // Preclear key lane written
  logic clr_wr; // Clear key lane written
  logic pre_good; // Step-one key correct
  logic clr_good; // Step-two key correct, in order
  logic restart; // Timer reset event
  logic bad_key; // Any wrong key this cycle

  // Match and window values come straight from the fuse halves
  assign configured_match_value = {fuse_match_high_i,
                                   fuse_match_low_i};
  assign configured_interval_value = {fuse_interval_high_i,
                                      fuse_interval_low_i};

  // Fuse enable always wins; the soft bit only matters if permitted
  assign active = fuse_enable_i ||
                  (!fuse_disable_setting_i && on_r);

  // No fetches in sleep, and the count stops at match
  assign advance = active && fetch_i && !sleep_i
                   && !expired;

  // Window opens once the count reaches the configured interval
  assign clear_window_open = active &&
                             (count >= configured_interval_value);

  // Key lanes: step one sits in the upper byte, step two in the lower
  assign pre_wr = wr_en && (wr_addr == deadman_pkg::OFF_PRECLEAR) &&
                  wr_strb[deadman_pkg::LANE_HI];
  assign clr_wr = wr_en && (wr_addr == deadman_pkg::OFF_CLEAR) &&
                  wr_strb[deadman_pkg::LANE_LO];

  // Step-one key check
  assign pre_good = (wr_data[deadman_pkg::PRECLEAR_KEY_LSB +: 8] ==
                     deadman_pkg::PRECLEAR_KEY_VALUE);

  // Step-two key is only right after an armed step one
  assign clr_good = (wr_data[deadman_pkg::CLEAR_KEY_LSB +: 8] ==
                     deadman_pkg::CLEAR_KEY_VALUE) &&
                    (preclear_key_field_r ==
                     deadman_pkg::PRECLEAR_KEY_VALUE);

  // A good clear is the timer reset event
  assign restart = clr_wr && clr_good;

  // Either wrong key raises the event
  assign bad_key = (pre_wr && !pre_good) || (clr_wr && !clr_good);

  // Bus front end
  axil_reg_slave u_bus (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_err_i(wr_err),
    .rd_en_o(rd_en),
    .rd_data_i(rd_data),
    .rd_err_i(rd_err)
  );

  // Fetch counter and match compare
  fetch_counter u_count (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .advance_i(advance),
    .restart_i(restart),
    .match_i(configured_match_value),
    .count_o(count),
    .expired_o(expired)
  );

  // Software enable bit, upper byte lane
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_r <= 1'b0;
    end else if (wr_en && (wr_addr == deadman_pkg::OFF_CONTROL) &&
                 wr_strb[deadman_pkg::LANE_HI]) begin
      on_r <= wr_data[deadman_pkg::CTRL_ON_BIT];
    end
  end

  // Step-one store: a good clear wipes it, else any write lands
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      preclear_key_field_r <= deadman_pkg::KEY_RESET;
    end else if (restart) begin
      preclear_key_field_r <= deadman_pkg::KEY_RESET;
    end else if (pre_wr) begin
      preclear_key_field_r <=
        wr_data[deadman_pkg::PRECLEAR_KEY_LSB +: 8];
    end
  end

  // Step-two store: wrong values are kept for software to see
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clear_key_field_r <= deadman_pkg::KEY_RESET;
    end else if (restart) begin
      clear_key_field_r <= deadman_pkg::KEY_RESET;
    end else if (clr_wr) begin
      clear_key_field_r <=
        wr_data[deadman_pkg::CLEAR_KEY_LSB +: 8];
    end
  end

  // Step-one error; set and clear cannot meet, both need bus writes
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      preclear_key_error_r <= 1'b0;
    end else if (pre_wr && !pre_good) begin
      preclear_key_error_r <= 1'b1;
    end else if (restart) begin
      preclear_key_error_r <= 1'b0;
    end
  end

  // Step-two error; only hardware clears it, on a good sequence
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clear_key_error_r <= 1'b0;
    end else if (clr_wr && !clr_good) begin
      clear_key_error_r <= 1'b1;
    end else if (restart) begin
      clear_key_error_r <= 1'b0;
    end
  end

  // Event flag; an expiry still held at match or a bad key wins over the clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      supervisor_event_flag_r <= 1'b0;
    end else if ((active && expired) || bad_key) begin
      supervisor_event_flag_r <= 1'b1;
    end else if (restart) begin
      supervisor_event_flag_r <= 1'b0;
    end
  end

  // Interrupt follows the event flag, one flop from the output
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= supervisor_event_flag_r;
    end
  end
  assign irq_o = irq_r;

  // Hold register snapshots the upper half on count reads
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upper_count_hold_r <= deadman_pkg::REG_RESET;
    end else if (rd_en && ((s_axi_araddr_i ==
                            deadman_pkg::OFF_COUNT_LOW) ||
                           (s_axi_araddr_i ==
                            deadman_pkg::OFF_COUNT_HIGH))) begin
      upper_count_hold_r <= count[31:16];
    end
  end

  // Write decode; count and mirror registers ignore writes
  always_comb begin
    unique case (wr_addr)
      deadman_pkg::OFF_CONTROL,
      deadman_pkg::OFF_PRECLEAR,
      deadman_pkg::OFF_CLEAR,
      deadman_pkg::OFF_STATUS,
      deadman_pkg::OFF_COUNT_LOW,
      deadman_pkg::OFF_COUNT_HIGH,
      deadman_pkg::OFF_CFG_COUNT_LOW,
      deadman_pkg::OFF_CFG_COUNT_HIGH,
      deadman_pkg::OFF_CFG_INTV_LOW,
      deadman_pkg::OFF_CFG_INTV_HIGH,
      deadman_pkg::OFF_HOLD: wr_err = 1'b0;
      default: wr_err = 1'b1; // Unmapped
    endcase
  end

  // Read decode; unused bits read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (s_axi_araddr_i)
      deadman_pkg::OFF_CONTROL: begin
        rd_data[deadman_pkg::CTRL_ON_BIT] = on_r;
      end
      deadman_pkg::OFF_PRECLEAR: begin
        rd_data[deadman_pkg::PRECLEAR_KEY_LSB +: 8] =
          preclear_key_field_r;
      end
      deadman_pkg::OFF_CLEAR: begin
        rd_data[deadman_pkg::CLEAR_KEY_LSB +: 8] = clear_key_field_r;
      end
      deadman_pkg::OFF_STATUS: begin
        rd_data[deadman_pkg::STAT_PRE_ERR_BIT] =
          preclear_key_error_r;
        rd_data[deadman_pkg::STAT_CLR_ERR_BIT] =
          clear_key_error_r;
        rd_data[deadman_pkg::STAT_EVENT_BIT] =
          supervisor_event_flag_r;
        rd_data[deadman_pkg::STAT_WIN_BIT] =
          clear_window_open;
      end
      deadman_pkg::OFF_COUNT_LOW: begin
        rd_data = widen(count[15:0]);
      end
      deadman_pkg::OFF_COUNT_HIGH: begin
        rd_data = widen(count[31:16]);
      end
      deadman_pkg::OFF_CFG_COUNT_LOW: begin
        rd_data = widen(fuse_match_low_i);
      end
      deadman_pkg::OFF_CFG_COUNT_HIGH: begin
        rd_data = widen(fuse_match_high_i);
      end
      deadman_pkg::OFF_CFG_INTV_LOW: begin
        rd_data = widen(fuse_interval_low_i);
      end
      deadman_pkg::OFF_CFG_INTV_HIGH: begin
        rd_data = widen(fuse_interval_high_i);
      end
      deadman_pkg::OFF_HOLD: begin
        rd_data = widen(upper_count_hold_r);
      end
      default: begin
        rd_err = 1'b1; // Unmapped reads zero with an error
      end
    endcase
  end
endmodule

// >>> testbench/deadman_assertions.sv
/*
  Port checker for the deadman supervisor: bus handshake timing,
  read data width and interrupt persistence. Assumes one clock and
  an active-low asynchronous reset; bound to every instance.
*/
module deadman_checker (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic irq_o
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  aw_pulse_a: assert property (s_axi_awready_o |=> !s_axi_awready_o)
    else $error("write address ready held too long");
  ar_pulse_a: assert property (s_axi_arready_o |=> !s_axi_arready_o)
    else $error("read address ready held too long");
  wr_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o &&
    s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
    else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o) else $error("read data late");
  // Stalled read must keep its data
  rd_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped while stalled");
  rd_cause_a: assert property ($rose(s_axi_rvalid_o)
    |-> $past(s_axi_arvalid_i && s_axi_arready_o))
    else $error("read data without request");
  rd_width_a: assert property (s_axi_rvalid_o |->
    s_axi_rdata_o[31:16] == 16'h0000) else $error("upper read bits set");
  // Only a completed write can clear the event
  irq_hold_a: assert property (irq_o && !s_axi_bvalid_o |=> irq_o)
    else $error("interrupt dropped without write");
  irq_fall_a: assert property ($fell(irq_o) |->
    $past(s_axi_bvalid_o)) else $error("interrupt fell without write");
endmodule
bind deadman_supervisor deadman_checker chk_u (.ref_clk_i, .rst_n_i,
  .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bvalid_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .irq_o);

// >>> testbench/testbench.sv
/*
  Self-checking bench for the deadman supervisor: bus tasks, fetch
  pulses and key sequences. Assumes the register map of the
  package and static fuse words: match 0x14, window interval 0x0a.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'h0, rst_n_i = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rd_q, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic fetch = 1'h0, sleep = 1'h0, fen = 1'h0, fdis = 1'h1;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp_q;
  int bad_count = 0, num_checks = 0, cyc = 0, i;
  // Fuse words tied: they are static in the device
  deadman_supervisor uut (.ref_clk_i, .rst_n_i, .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .fetch_i(fetch), .sleep_i(sleep),
    .fuse_enable_i(fen), .fuse_disable_setting_i(fdis),
    .fuse_match_low_i(16'h0014), .fuse_match_high_i(16'h0000),
    .fuse_interval_low_i(16'h000a), .fuse_interval_high_i(16'h0000),
    .irq_o(irq));
  always #50 ref_clk_i = ~ref_clk_i;
  // Cut a hang short
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge ref_clk_i);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    resp_q = bresp;
    bready <= 1'h0;
  endtask
  // Read ready comes late on purpose, so the slave must hold data
  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk_i);
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge ref_clk_i);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h1;
    @(posedge ref_clk_i);
    rd_q = rdata;
    resp_q = rresp;
    rready <= 1'h0;
  endtask
  task automatic rc(input string nm, input logic [11:0] a,
                    input logic [31:0] e);
    rd(a);
    chk(nm, e, rd_q);
  endtask
  // Fetch high for exactly n sampling edges
  task automatic pulse(input int n);
    @(posedge ref_clk_i);
    fetch <= 1'h1;
    repeat (n) @(posedge ref_clk_i);
    fetch <= 1'h0;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    for (i = 0; i < 6; i++) rc("reset", 12'(4 * i), 32'h0);
    rc("cfg_lo", 12'h018, 32'h14);
    rc("cfg_hi", 12'h01c, 32'h0);
    rc("ivl_lo", 12'h020, 32'ha);
    rc("ivl_hi", 12'h024, 32'h0);
    wr(12'h000, 32'hffff_ffff);
    rc("control", 12'h000, 32'h8000);
    pulse(5);
    rc("count_off", 12'h010, 32'h0);
    fdis <= 1'h0;
    pulse(5);
    rc("count", 12'h010, 32'h5);
    rc("win_shut", 12'h00c, 32'h0);
    sleep <= 1'h1;
    pulse(4);
    rc("count_sleep", 12'h010, 32'h5);
    sleep <= 1'h0;
    pulse(7);
    rc("count_hi", 12'h014, 32'h0);
    rc("hold", 12'h028, 32'h0);
    rc("win_open", 12'h00c, 32'h1);
    wr(12'h004, 32'h4000);
    rc("armed", 12'h004, 32'h4000);
    wr(12'h008, 32'h0008);
    rc("restart", 12'h010, 32'h0);
    rc("pre_clr", 12'h004, 32'h0);
    rc("clr_clr", 12'h008, 32'h0);
    wr(12'h008, 32'h0055);
    rc("bad_clr", 12'h00c, 32'h60);
    rc("clr_cap", 12'h008, 32'h55);
    rc("pre_kept", 12'h004, 32'h0);
    chk("irq_key", 32'h1, {31'h0, irq});
    wr(12'h004, 32'h1200);
    rc("bad_pre", 12'h00c, 32'he0);
    rc("pre_cap", 12'h004, 32'h1200);
    wr(12'h004, 32'h4000);
    wr(12'h008, 32'h0008);
    rc("recover", 12'h00c, 32'h0);
    chk("irq_off", 32'h0, {31'h0, irq});
    wr(12'h000, 32'h0);
    fen <= 1'h1;
    pulse(25);
    rc("expired", 12'h010, 32'h14);
    rc("event", 12'h00c, 32'h21);
    chk("irq_exp", 32'h1, {31'h0, irq});
    rd(12'h040);
    chk("unmapped", 32'h2, {30'h0, resp_q});
    chk("unmap_data", 32'h0, rd_q);
    wr(12'h00c, 32'hffff);
    chk("ro_resp", 32'h0, {30'h0, resp_q});
    rc("ro_stat", 12'h00c, 32'h21);
    // Unmapped write must answer with a slave error
    wr(12'h040, 32'h0);
    chk("wr_unmap", 32'h2, {30'h0, resp_q});
    test_done();
  end
endmodule
